// file: rtl/tbrx_cfg.svh
`ifndef TBRX_CFG_SVH
`define TBRX_CFG_SVH
// Register indices (word offsets on the plain port)
`define TBRX_REG_BMC 4'h0
`define TBRX_REG_ADV 4'h4
`define TBRX_REG_EXP 4'h6
`define TBRX_REG_NPT 4'h7
`define TBRX_REG_PNP 4'h8
`define TBRX_REG_LINE 4'h9
// Basic mode control fields
`define TBRX_BMC_RESET 15
`define TBRX_BMC_SPEED 13
`define TBRX_BMC_ANEN 12
`define TBRX_BMC_PWRUP 11
`define TBRX_BMC_RESTART 9
`define TBRX_BMC_DUPLEX 8
`define TBRX_BMC_RST_VAL 16'h3100
`define TBRX_ADV_RST_VAL 16'h01E1
`define TBRX_NPT_RST_VAL 16'h2001
// Advertisement / expansion / page fields
`define TBRX_ADV_NP 15
`define TBRX_EXP_PAGE 1
`define TBRX_EXP_NPABLE 2
`define TBRX_PAGE_MORE 15
// Line status register fields
`define TBRX_LINE_JAB 0
`define TBRX_LINE_POLINV 1
`define TBRX_LINE_ANDONE 2
`define TBRX_LINE_PD100 3
`define TBRX_LINE_CRS 4
`define TBRX_LINE_COL 5
// Timing
`define TBRX_CLK_MHZ 200
`define TBRX_SQ_MIN_NS 50
`define TBRX_SQ_CYC ((`TBRX_SQ_MIN_NS * `TBRX_CLK_MHZ + 999) / 1000)
`define TBRX_JAB_MS 100
`define TBRX_UNJAB_MS 500
`define TBRX_JAB_CYC (`TBRX_JAB_MS * 1000 * `TBRX_CLK_MHZ)
`define TBRX_UNJAB_CYC (`TBRX_UNJAB_MS * 1000 * `TBRX_CLK_MHZ)
`define TBRX_TX_QUAL_EDGES 5
`endif

// file: rtl/tbrx_pkg.sv
package tbrx_pkg;
  typedef enum logic [3:0] {
    TBRX_AN_IDLE = 4'h1,
    TBRX_AN_BASE = 4'h2,
    TBRX_AN_WAIT = 4'h4,
    TBRX_AN_DONE = 4'h8
  } tbrx_an_t;
  typedef enum logic [2:0] {
    TBRX_SQ_IDLE = 3'h1,
    TBRX_SQ_OPP = 3'h2,
    TBRX_SQ_ORIG = 3'h4
  } tbrx_sq_t;
endpackage

// file: rtl/tbrx_line_if.sv
`timescale 1ns/1ps
interface tbrx_line_if;
  logic tx_en;
  logic speed_10;
  logic tx_gate;
  logic jabbered;
  modport ctrl (output tx_en, output speed_10, input tx_gate, input jabbered);
  modport jab (input tx_en, input speed_10, output tx_gate, output jabbered);
endinterface

// file: rtl/tbrx_jabber.sv
`timescale 1ns/1ps
`include "tbrx_cfg.svh"
module tbrx_jabber
  import tbrx_pkg::*;
#(
  parameter int JAB_CYC = `TBRX_JAB_CYC,
  parameter int UNJAB_CYC = `TBRX_UNJAB_CYC
)(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic soft_rst_i,
  // Line
  tbrx_line_if.jab line
);
  logic [36:0] cnt_r;
  logic jab_r;

  // Counter on the core clock; cleared by either reset
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i || soft_rst_i || !line.speed_10)
    begin
      cnt_r <= 37'h0;
      jab_r <= 1'b0;
    end
    else if (!jab_r)
    begin
      if (!line.tx_en)
        cnt_r <= 37'h0;
      else if (cnt_r >= 37'(JAB_CYC - 1))
      begin
        jab_r <= 1'b1;
        cnt_r <= 37'h0;
      end
      else
        cnt_r <= cnt_r + 37'h1;
    end
    else
    begin
      if (line.tx_en)
        cnt_r <= 37'h0;
      else if (cnt_r >= 37'(UNJAB_CYC - 1))
      begin
        jab_r <= 1'b0;
        cnt_r <= 37'h0;
      end
      else
        cnt_r <= cnt_r + 37'h1;
    end
  end

  assign line.jabbered = jab_r;
  assign line.tx_gate = line.tx_en && !jab_r;

  AST_JAB_HOLD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    jab_r && line.tx_en && !soft_rst_i && line.speed_10 |=> jab_r)
    else $error("jabber released while enable high");
  AST_JAB_GATE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !jab_r ##1 jab_r |-> $past(line.tx_en) && $past(line.speed_10))
    else $error("jabber tripped without 10M transmit");
  AST_JAB_100: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !line.speed_10 |=> !jab_r)
    else $error("jabber active at 100M");
endmodule

// file: rtl/tbrx_ctrl.sv
`timescale 1ns/1ps
`include "tbrx_cfg.svh"
// Functional notes
// - Squelch: opposite level after >=50ns, original again after >=50ns, else reject.
// - While transmitting, five consecutive valid transitions qualify data; squelch then resets.
// - Half duplex: collision output held for whole receive/transmit overlap.
// - Collision during ongoing reception is reported without added delay.
// - Half duplex: carrier sense on transmit or receive.
// - Full duplex: carrier sense only from receive.
// - Carrier sense rises after squelch qualification, falls at end of packet.
// - Jabber timer cuts transmitter after about 100ms of transmission.
// - Transmitter stays off until enable low continuously about 500ms.
// - Jabber active only at 10 Mb/s.
// - Detect reversed receive polarity and correct; transmit link pulses default inverted.
// - Full duplex: concurrent transmit and receive never signal collision.
// - Negotiation transmits on one pair, listens on other, per crossover state.
// - Non-negotiating partner: choose 10 or 100 by parallel detection.
// - Negotiation starts on reset release, soft reset, restart bit, power-up bit.
// - With enable bit set, also start on link fail; the restart bit starts it regardless of enable.
// - Enable bit change takes effect only at next restart.
// - Expansion bit 1 rises on new page; software polls then reads page.
// - Software writes transmit page after reading; then received page may be overwritten.
// - Next page transmission waits for the transmit page register write.
module tbrx_ctrl
  import tbrx_pkg::*;
#(
  parameter int JAB_CYC = `TBRX_JAB_CYC,
  parameter int UNJAB_CYC = `TBRX_UNJAB_CYC
)(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Receive line comparators (asynchronous)
  input wire logic sq_pos_i,
  input wire logic sq_neg_i,
  input wire logic rx_eop_i,
  input wire logic link_pulse_i,
  input wire logic link_fail_i,
  input wire logic mdix_i,
  // Negotiation front end
  input wire logic page_rx_i,
  input wire logic [15:0] page_rx_data_i,
  input wire logic partner_an_i,
  input wire logic pd_100_i,
  output logic page_tx_req_o,
  output logic [15:0] page_tx_data_o,
  output logic an_tx_pair_b_o,
  // MII side
  input wire logic tx_en_i,
  output logic crs_o,
  output logic col_o,
  output logic tx_out_en_o,
  output logic rx_pol_inv_o,
  output logic lp_pol_inv_o,
  output logic speed_10_o,
  output logic full_duplex_o
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [5:0] sy1_r;
  logic [5:0] sy2_r;
  logic pos_s;
  logic neg_s;
  logic eop_s;
  logic lp_s;
  logic lf_s;
  logic mdix_s;
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      sy1_r <= 6'h0;
      sy2_r <= 6'h0;
    end
    else
    begin
      sy1_r <= {mdix_i, link_fail_i, link_pulse_i, rx_eop_i, sq_neg_i, sq_pos_i};
      sy2_r <= sy1_r;
    end
  end
  assign {mdix_s, lf_s, lp_s, eop_s, neg_s, pos_s} = sy2_r;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [15:0] bmc_r;
  logic [15:0] adv_r;
  logic [15:0] npt_r;
  logic [15:0] pnp_r;
  logic an_en_live_r;
  logic page_new_r;
  logic pnp_read_r;
  logic np_armed_r;
  logic partner_more_r;
  logic soft_rst;
  logic restart;
  logic an_start;
  logic wr_bmc;
  logic wr_npt;
  logic rd_pnp;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  assign wr_bmc = reg_wr_i && hit(reg_addr_i, `TBRX_REG_BMC);
  assign wr_npt = reg_wr_i && hit(reg_addr_i, `TBRX_REG_NPT);
  assign rd_pnp = reg_rd_i && hit(reg_addr_i, `TBRX_REG_PNP);
  assign soft_rst = wr_bmc && reg_wdata_i[`TBRX_BMC_RESET];
  assign restart = wr_bmc && reg_wdata_i[`TBRX_BMC_RESTART];

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i || soft_rst)
    begin
      bmc_r <= `TBRX_BMC_RST_VAL;
      adv_r <= `TBRX_ADV_RST_VAL;
      npt_r <= `TBRX_NPT_RST_VAL;
    end
    else
    begin
      if (wr_bmc)
        bmc_r <= reg_wdata_i & ~(16'h1 << `TBRX_BMC_RESTART);
      if (reg_wr_i && hit(reg_addr_i, `TBRX_REG_ADV))
        adv_r <= reg_wdata_i;
      if (wr_npt)
        npt_r <= reg_wdata_i;
    end
  end

  // Enable bit is latched only at a restart, so live edits do nothing
  logic pwrup_rise;
  logic pwrup_q_r;
  logic lf_q_r;
  logic boot_r;
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      an_en_live_r <= 1'b1;
      pwrup_q_r <= 1'b0;
      lf_q_r <= 1'b0;
      boot_r <= 1'b1;
    end
    else
    begin
      pwrup_q_r <= bmc_r[`TBRX_BMC_PWRUP];
      lf_q_r <= lf_s;
      boot_r <= 1'b0;
      if (restart || soft_rst)
        an_en_live_r <= soft_rst ? 1'b1 : reg_wdata_i[`TBRX_BMC_ANEN];
    end
  end
  assign pwrup_rise = bmc_r[`TBRX_BMC_PWRUP] && !pwrup_q_r;
  // Reset release, soft reset, restart, power-up; link fail only when enabled
  assign an_start = boot_r || soft_rst || restart || pwrup_rise
    || (an_en_live_r && lf_s && !lf_q_r);

  // ------------------------------------------------------------
  // Negotiation engine
  // ------------------------------------------------------------
  tbrx_an_t an_r;
  logic pd100_r;
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      an_r <= TBRX_AN_IDLE;
      pd100_r <= 1'b0;
      page_tx_req_o <= 1'b0;
      page_tx_data_o <= 16'h0;
      np_armed_r <= 1'b0;
    end
    else if (an_start)
    begin
      an_r <= TBRX_AN_BASE;
      page_tx_req_o <= 1'b1;
      page_tx_data_o <= adv_r;
      np_armed_r <= 1'b0;
    end
    else
    begin
      page_tx_req_o <= 1'b0;
      if (wr_npt)
        np_armed_r <= 1'b1;
      case (an_r)
        TBRX_AN_IDLE:
          an_r <= TBRX_AN_IDLE;
        TBRX_AN_BASE:
          if (!partner_an_i && lp_s)
          begin
            pd100_r <= pd_100_i;
            an_r <= TBRX_AN_DONE;
          end
          else if (page_rx_i)
            an_r <= adv_r[`TBRX_ADV_NP] ? TBRX_AN_WAIT : TBRX_AN_DONE;
        TBRX_AN_WAIT:
          if (np_armed_r || wr_npt)
          begin
            page_tx_req_o <= 1'b1;
            page_tx_data_o <= wr_npt ? reg_wdata_i : npt_r;
            np_armed_r <= 1'b0;
            if (!(wr_npt ? reg_wdata_i[`TBRX_PAGE_MORE] : npt_r[`TBRX_PAGE_MORE])
                && !partner_more_r)
              an_r <= TBRX_AN_DONE;
          end
        TBRX_AN_DONE:
          an_r <= TBRX_AN_DONE;
        default:
          an_r <= TBRX_AN_IDLE;
      endcase
    end
  end

  // Received page store; new pages overwrite only after the received page is read, or in the cycle of a transmit page write
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i || soft_rst)
    begin
      pnp_r <= 16'h0;
      page_new_r <= 1'b0;
      pnp_read_r <= 1'b1;
      partner_more_r <= 1'b0;
    end
    else
    begin
      if (page_rx_i && an_r == TBRX_AN_WAIT && (pnp_read_r || wr_npt))
      begin
        pnp_r <= page_rx_data_i;
        partner_more_r <= page_rx_data_i[`TBRX_PAGE_MORE];
        page_new_r <= 1'b1;
        pnp_read_r <= 1'b0;
      end
      else
      begin
        if (reg_rd_i && hit(reg_addr_i, `TBRX_REG_EXP))
          page_new_r <= 1'b0;
        if (rd_pnp)
          pnp_read_r <= 1'b1;
        // Base page: flag it and note whether the partner has more to send
        if (page_rx_i && an_r == TBRX_AN_BASE)
        begin
          page_new_r <= 1'b1;
          partner_more_r <= page_rx_data_i[`TBRX_PAGE_MORE];
        end
      end
    end
  end

  AST_NP_HOLD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    an_r == TBRX_AN_WAIT && !np_armed_r && !wr_npt && !an_start |=> !page_tx_req_o)
    else $error("next page sent before transmit page written");

  // ------------------------------------------------------------
  // Squelch and polarity
  // ------------------------------------------------------------
  tbrx_sq_t sq_r;
  logic [7:0] sq_cnt_r;
  logic sq_first_pos_r;
  logic [2:0] tx_edges_r;
  logic rx_act_r;
  logic pol_r;
  logic lvl_a;
  logic lvl_b;
  assign lvl_a = sq_first_pos_r ? pos_s : neg_s;
  assign lvl_b = sq_first_pos_r ? neg_s : pos_s;
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i || soft_rst)
    begin
      sq_r <= TBRX_SQ_IDLE;
      sq_cnt_r <= 8'h0;
      sq_first_pos_r <= 1'b1;
      tx_edges_r <= 3'h0;
      rx_act_r <= 1'b0;
    end
    else if (rx_act_r)
    begin
      if (eop_s)
        rx_act_r <= 1'b0;
    end
    // End of activity drops a half-qualified start, so no stale state carries over
    else if (eop_s)
      sq_r <= TBRX_SQ_IDLE;
    else
    begin
      if (sq_cnt_r != 8'hFF)
        sq_cnt_r <= sq_cnt_r + 8'h1;
      case (sq_r)
        TBRX_SQ_IDLE:
          if (pos_s || neg_s)
          begin
            sq_first_pos_r <= pos_s;
            sq_cnt_r <= 8'h0;
            tx_edges_r <= 3'h1;
            sq_r <= TBRX_SQ_OPP;
          end
        TBRX_SQ_OPP:
          if (lvl_b)
          begin
            // Count reads one less than the cycles since the previous level
            if (sq_cnt_r >= 8'(`TBRX_SQ_CYC - 1))
            begin
              sq_cnt_r <= 8'h0;
              tx_edges_r <= tx_edges_r + 3'h1;
              sq_r <= TBRX_SQ_ORIG;
            end
            else
              sq_r <= TBRX_SQ_IDLE;
          end
        TBRX_SQ_ORIG:
          if (lvl_a)
          begin
            if (sq_cnt_r < 8'(`TBRX_SQ_CYC - 1))
              sq_r <= TBRX_SQ_IDLE;
            else if (!tx_en_i || tx_edges_r + 3'h1 >= 3'(`TBRX_TX_QUAL_EDGES))
            begin
              rx_act_r <= 1'b1;
              sq_r <= TBRX_SQ_IDLE;
            end
            else
            begin
              sq_cnt_r <= 8'h0;
              tx_edges_r <= tx_edges_r + 3'h1;
              sq_r <= TBRX_SQ_OPP;
            end
          end
        default:
          sq_r <= TBRX_SQ_IDLE;
      endcase
    end
  end

  // A negative-going link pulse means the pair is swapped
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i || soft_rst)
      pol_r <= 1'b0;
    else if (speed_10_o && lp_s && !rx_act_r)
      pol_r <= neg_s && !pos_s;
  end

  // ------------------------------------------------------------
  // Jabber and MII outputs
  // ------------------------------------------------------------
  tbrx_line_if line();
  assign line.tx_en = tx_en_i;
  assign line.speed_10 = speed_10_o;
  tbrx_jabber #(
    .JAB_CYC(JAB_CYC),
    .UNJAB_CYC(UNJAB_CYC)
  ) u_jab (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .soft_rst_i(soft_rst),
    .line(line)
  );

  logic fdx;
  logic spd10;
  assign fdx = bmc_r[`TBRX_BMC_DUPLEX];
  assign spd10 = (an_r == TBRX_AN_DONE && !partner_an_i) ? !pd100_r : !bmc_r[`TBRX_BMC_SPEED];
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      crs_o <= 1'b0;
      col_o <= 1'b0;
      tx_out_en_o <= 1'b0;
      rx_pol_inv_o <= 1'b0;
      lp_pol_inv_o <= 1'b1;
      speed_10_o <= 1'b1;
      full_duplex_o <= 1'b0;
      an_tx_pair_b_o <= 1'b0;
    end
    else
    begin
      crs_o <= rx_act_r || (!fdx && tx_en_i);
      col_o <= !fdx && rx_act_r && tx_en_i;
      tx_out_en_o <= speed_10_o ? line.tx_gate : tx_en_i;
      rx_pol_inv_o <= pol_r;
      lp_pol_inv_o <= 1'b1;
      speed_10_o <= spd10;
      full_duplex_o <= fdx;
      an_tx_pair_b_o <= mdix_s;
    end
  end

  AST_COL_FDX: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    fdx |=> !col_o)
    else $error("collision in full duplex");
  AST_COL_HDX: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !fdx && rx_act_r && tx_en_i |=> col_o)
    else $error("overlap without collision");
  AST_CRS_TX: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !fdx && tx_en_i |=> crs_o)
    else $error("no carrier sense on half duplex transmit");
  AST_CRS_FDX: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    fdx && !rx_act_r |=> !crs_o)
    else $error("carrier sense without receive in full duplex");
  AST_CRS_EOP: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    rx_act_r && eop_s && !soft_rst ##1 (fdx || !tx_en_i) |=> !crs_o)
    else $error("carrier sense held after end of packet");
  AST_TX_CUT: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    speed_10_o && line.jabbered |=> !tx_out_en_o)
    else $error("transmit output enabled during jabber");
  AST_AN_START: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    restart |=> an_r == TBRX_AN_BASE && page_tx_req_o)
    else $error("restart did not start negotiation");
  AST_AN_EN: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    wr_bmc && !restart && !soft_rst |=> $stable(an_en_live_r))
    else $error("enable changed without restart");
  AST_PAGE_FLAG: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    page_rx_i && an_r == TBRX_AN_WAIT && pnp_read_r && !soft_rst |=> page_new_r)
    else $error("page flag not raised");

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= 16'h0;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `TBRX_REG_BMC: reg_rdata_o <= bmc_r;
        `TBRX_REG_ADV: reg_rdata_o <= adv_r;
        `TBRX_REG_EXP: reg_rdata_o <= 16'(({15'h0, 1'b1} << `TBRX_EXP_NPABLE)
                                         | ({15'h0, page_new_r} << `TBRX_EXP_PAGE));
        `TBRX_REG_NPT: reg_rdata_o <= npt_r;
        `TBRX_REG_PNP: reg_rdata_o <= pnp_r;
        `TBRX_REG_LINE: reg_rdata_o <= 16'(({15'h0, line.jabbered} << `TBRX_LINE_JAB)
                                          | ({15'h0, pol_r} << `TBRX_LINE_POLINV)
                                          | ({15'h0, an_r == TBRX_AN_DONE} << `TBRX_LINE_ANDONE)
                                          | ({15'h0, pd100_r} << `TBRX_LINE_PD100)
                                          | ({15'h0, crs_o} << `TBRX_LINE_CRS)
                                          | ({15'h0, col_o} << `TBRX_LINE_COL));
        default: reg_rdata_o <= 16'h0;
      endcase
    end
    else
      reg_rdata_o <= 16'h0;
  end
endmodule

// file: verification/tbrx_mac_model.sv
`timescale 1ns/1ps
module tbrx_mac_model (
  // Clock
  input wire logic clk_i,
  // Media side
  input wire logic crs_i,
  output logic tx_en_o
);
  initial tx_en_o = 1'b0;
  // A real MAC defers to carrier; collision tests switch deferral off
  task tx(input bit on, input bit defer);
    int k;
    k = 0;
    while (defer && crs_i === 1'b1 && k < 400)
    begin
      @(posedge clk_i);
      k++;
    end
    @(posedge clk_i);
    tx_en_o <= on;
  endtask
endmodule

// file: verification/tb_tbrx_ctrl.sv
`timescale 1ns/1ps
module tb_tbrx_ctrl;
  logic core_clk_i = 1'b0;
  logic reset_n_i, reg_wr_i, reg_rd_i, sq_pos_i, sq_neg_i, rx_eop_i;
  logic link_pulse_i, link_fail_i, mdix_i, page_rx_i, partner_an_i, pd_100_i, tx_en_i;
  logic [3:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, page_rx_data_i, page_tx_data_o, last_pg, d;
  logic page_tx_req_o, an_tx_pair_b_o, crs_o, col_o, tx_out_en_o, rx_pol_inv_o, lp_pol_inv_o;
  logic speed_10_o, full_duplex_o;
  int bad_count = 0;
  int checks_done = 0;
  int n_pg = 0;
  int n0;

  always #2.5 core_clk_i = ~core_clk_i;

  // Short jabber counts keep the run small
  tbrx_ctrl #(.JAB_CYC(50), .UNJAB_CYC(100)) dut_u (
    .core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .sq_pos_i, .sq_neg_i, .rx_eop_i, .link_pulse_i, .link_fail_i, .mdix_i,
    .page_rx_i, .page_rx_data_i, .partner_an_i, .pd_100_i, .page_tx_req_o, .page_tx_data_o,
    .an_tx_pair_b_o, .tx_en_i, .crs_o, .col_o, .tx_out_en_o, .rx_pol_inv_o, .lp_pol_inv_o,
    .speed_10_o, .full_duplex_o
  );

  tbrx_mac_model mac_u (.clk_i(core_clk_i), .crs_i(crs_o), .tx_en_o(tx_en_i));

  always @(posedge core_clk_i)
    if (page_tx_req_o === 1'b1)
    begin
      n_pg <= n_pg + 1;
      last_pg <= page_tx_data_o;
    end

  // ----------
  // Tasks
  // ----------
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
    chk(d, e);
  endtask

  // Alternating comparator levels, each held gap cycles
  task sq(input int from, input int to, input int gap);
    for (int i = from; i < to; i++)
    begin
      @(posedge core_clk_i);
      sq_pos_i <= ~i[0];
      sq_neg_i <= i[0];
      repeat (gap - 1) @(posedge core_clk_i);
    end
  endtask

  task eop;
    @(posedge core_clk_i);
    sq_pos_i <= 1'b0;
    sq_neg_i <= 1'b0;
    rx_eop_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rx_eop_i <= 1'b0;
    wt(3);
  endtask

  task prx(input logic [15:0] v);
    @(posedge core_clk_i);
    page_rx_i <= 1'b1;
    page_rx_data_i <= v;
    @(posedge core_clk_i);
    page_rx_i <= 1'b0;
    wt(3);
  endtask

  task lfail;
    @(posedge core_clk_i);
    link_fail_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    link_fail_i <= 1'b0;
    wt(6);
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    bad_count++;
    end_sim();
  end

  // ----------
  // Tests
  // ----------
  initial
  begin
    reset_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    sq_pos_i = 1'b0;
    sq_neg_i = 1'b0;
    rx_eop_i = 1'b0;
    link_pulse_i = 1'b0;
    link_fail_i = 1'b0;
    mdix_i = 1'b0;
    page_rx_i = 1'b0;
    page_rx_data_i = 16'h0000;
    partner_an_i = 1'b1;
    pd_100_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    wt(4);
    chk(16'(n_pg), 16'h0001);
    chk(last_pg, 16'h01E1);
    chk(16'(lp_pol_inv_o), 16'h0001);
    rd(4'h0, 16'h3100);
    rd(4'h4, 16'h01E1);
    rd(4'h7, 16'h2001);
    wr(4'h6, 16'hFFFF);
    rd(4'h6, 16'h0004);
    wr(4'hA, 16'hFFFF);
    rd(4'hA, 16'h0000);
    @(posedge core_clk_i);
    mdix_i <= 1'b1;
    wt(5);
    chk(16'(an_tx_pair_b_o), 16'h0001);
    @(posedge core_clk_i);
    mdix_i <= 1'b0;
    wt(5);
    chk(16'(an_tx_pair_b_o), 16'h0000);
    // Enable cleared without restart must still honour link fail
    wr(4'h0, 16'h0000);
    lfail();
    chk(16'(n_pg), 16'h0002);
    wr(4'h0, 16'h0200);
    wt(3);
    chk(16'(n_pg), 16'h0003);
    rd(4'h0, 16'h0000);
    lfail();
    chk(16'(n_pg), 16'h0003);
    chk(16'(speed_10_o), 16'h0001);
    sq(0, 3, 8);
    wt(6);
    chk(16'(crs_o), 16'h0000);
    eop();
    sq(0, 3, 10);
    wt(5);
    chk(16'(crs_o), 16'h0001);
    chk(16'(col_o), 16'h0000);
    mac_u.tx(1'b1, 1'b0);
    wt(1);
    chk(16'(col_o), 16'h0001);
    wt(6);
    chk(16'(col_o), 16'h0001);
    eop();
    chk(16'(crs_o), 16'h0001);
    chk(16'(col_o), 16'h0000);
    mac_u.tx(1'b0, 1'b0);
    wt(3);
    chk(16'(crs_o), 16'h0000);
    wr(4'h0, 16'h0100);
    mac_u.tx(1'b1, 1'b1);
    wt(3);
    chk(16'(crs_o), 16'h0000);
    sq(0, 4, 12);
    wt(4);
    chk(16'(crs_o), 16'h0000);
    sq(4, 6, 12);
    wt(4);
    chk(16'(crs_o), 16'h0001);
    chk(16'(col_o), 16'h0000);
    eop();
    mac_u.tx(1'b0, 1'b0);
    // The long full-duplex transmit tripped the jabber: let it unjab first
    wt(110);
    wr(4'h0, 16'h0000);
    mac_u.tx(1'b1, 1'b1);
    wt(40);
    chk(16'(tx_out_en_o), 16'h0001);
    wt(20);
    chk(16'(tx_out_en_o), 16'h0000);
    rd(4'h9, 16'h0011);
    wt(100);
    chk(16'(tx_out_en_o), 16'h0000);
    mac_u.tx(1'b0, 1'b0);
    wt(80);
    mac_u.tx(1'b1, 1'b0);
    wt(3);
    chk(16'(tx_out_en_o), 16'h0000);
    mac_u.tx(1'b0, 1'b0);
    wt(110);
    mac_u.tx(1'b1, 1'b0);
    wt(3);
    chk(16'(tx_out_en_o), 16'h0001);
    mac_u.tx(1'b0, 1'b0);
    wr(4'h0, 16'h2000);
    mac_u.tx(1'b1, 1'b1);
    wt(80);
    chk(16'(tx_out_en_o), 16'h0001);
    mac_u.tx(1'b0, 1'b0);
    // Next pages: software paces every page after the base page
    wr(4'h4, 16'h81E1);
    n0 = n_pg;
    wr(4'h0, 16'h3300);
    wt(3);
    chk(16'(n_pg - n0), 16'h0001);
    chk(last_pg, 16'h81E1);
    prx(16'hC1E1);
    rd(4'h6, 16'h0006);
    rd(4'h6, 16'h0004);
    wt(20);
    chk(16'(n_pg - n0), 16'h0001);
    wr(4'h7, 16'h2001);
    wt(3);
    chk(16'(n_pg - n0), 16'h0002);
    chk(last_pg, 16'h2001);
    prx(16'hA123);
    rd(4'h6, 16'h0006);
    rd(4'h8, 16'hA123);
    wr(4'h7, 16'h2001);
    wt(3);
    chk(16'(n_pg - n0), 16'h0003);
    prx(16'h0456);
    rd(4'h8, 16'h0456);
    // Partner's last page seen: one more null page closes the exchange
    wr(4'h7, 16'h2001);
    rd(4'h9, 16'h0004);
    chk(16'(n_pg - n0), 16'h0004);
    // Swapped pair: link pulses arrive on the negative comparator
    wr(4'h0, 16'h0100);
    @(posedge core_clk_i);
    link_pulse_i <= 1'b1;
    sq_neg_i <= 1'b1;
    wt(6);
    chk(16'(rx_pol_inv_o), 16'h0001);
    chk(16'(full_duplex_o), 16'h0001);
    // Partner without negotiation: parallel detection picks 100 Mb/s
    @(posedge core_clk_i);
    link_pulse_i <= 1'b0;
    sq_neg_i <= 1'b0;
    partner_an_i <= 1'b0;
    pd_100_i <= 1'b1;
    wr(4'h0, 16'h1200);
    @(posedge core_clk_i);
    link_pulse_i <= 1'b1;
    wt(6);
    chk(16'(speed_10_o), 16'h0000);
    chk(16'(rx_pol_inv_o), 16'h0000);
    rd(4'h9, 16'h000C);
    // Power-up bit and soft reset each start negotiation
    n0 = n_pg;
    wr(4'h0, 16'h0800);
    wt(3);
    chk(16'(n_pg - n0), 16'h0001);
    wr(4'h0, 16'h8000);
    rd(4'h0, 16'h3100);
    chk(16'(n_pg - n0), 16'h0002);
    end_sim();
  end
endmodule
